// ==== rtl/rsm_reset_ctrl.sv ====
`include "rsm_cfg.svh"

// Overview of operation
// - cause register writes need protection unlock
// - write zero clears; hardware set wins
// - pin or power-on clears cause register
// - watchdog reset sets cause bit 4
// - supply-monitor reset keeps cause bit 4
// - writing zero bit 0 clears low-voltage flag
// - cause register byte access, bit 0 write-only
// - low-voltage cause register is read-only
// - low-voltage flag set/cleared per reset source
// - hold reset while pin low, release rising
// - wait oscillation settle time before CPU
// - clocks stopped in reset, CPU div8
// - pins high impedance, peripherals initialised in reset
// - RAM kept unless power-on or write collision
// - watchdog overflow in reset mode resets system
// - watchdog reset self-releases after fixed delay
// - supply control protected, bit 0 read-only
// - supply control 00h, or 82h after monitor
// - bit 7 enables low-voltage detection
// - bit 1 selects interrupt or reset action
// - flag zero when supply high or disabled
// - two levels, runs in low-power modes
// - flag one when enabled and supply low
// - flag drives interrupt in interrupt action
// - reset action locks supply control writes
module rsm_reset_ctrl
	import rsm_pkg::*;
#(
	parameter int SETTLE_CYCLES = `RSM_SETTLE_OSC_CYCLES
)
(
	input wire logic ref_clk,
	input wire logic srst,
	input rsm_wb_req_type wbReq,
	output rsm_wb_rsp_type wbRsp,
	input wire logic resetPinN,
	input wire logic porDetect,
	input wire logic supplyBelow,
	input wire logic wdtOverflow,
	input wire logic wdtResetMode,
	input wire logic ramWriteActive,
	output rsm_sys_ctl_type sysCtl,
	output logic supplyMonitorIrq,
	output logic ramDataSuspect
);

	localparam logic [16:0] SETTLE_LAST = 17'(SETTLE_CYCLES - 1);
	localparam logic [16:0] WDT_LAST = 17'(`RSM_WDT_HOLD_CYCLES - 1);
	// Named copies so single bits can be picked out of them
	localparam logic [7:0] SUPPLY_LV = `RSM_SUPPLY_LVRESET;
	localparam logic [7:0] PROTECT_KEY = `RSM_PROTECT_KEY;

	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------
	function automatic rsm_reg_type decodeReg(input logic [31:0] adr);
		rsm_reg_type r;
		r = RS_NONE;
		case (adr)
			`RSM_ADDR_CAUSE: r = RS_CAUSE;
			`RSM_ADDR_LVCAUSE: r = RS_LVCAUSE;
			`RSM_ADDR_SUPPLY: r = RS_SUPPLY;
			`RSM_ADDR_PROTECT: r = RS_PROTECT;
			default: r = RS_NONE;
		endcase
		return r;
	endfunction

	// ------------------------------------------------------------------
	// Phase decode
	// ------------------------------------------------------------------
	// Shared by the capture guard and the system control image
	function automatic logic isResetPhase(input rsm_phase_type p);
		logic r;
		r = (p == PH_HOLD) || (p == PH_WDT);
		return r;
	endfunction

	// ------------------------------------------------------------------
	// Register read images
	// ------------------------------------------------------------------
	// Undefined bits read zero so software sees a stable value
	function automatic logic [7:0] causeImage(input logic wdtFlag);
		logic [7:0] b;
		b = 8'h00;
		b[`RSM_CAUSE_WDT_BIT] = wdtFlag;
		return b;
	endfunction

	function automatic logic [7:0] lvCauseImage(input logic lvFlag);
		logic [7:0] b;
		b = 8'h00;
		b[`RSM_LVCAUSE_FLAG_BIT] = lvFlag;
		return b;
	endfunction

	function automatic logic [7:0] supplyImage(
		input logic en,
		input logic act,
		input logic below
	);
		logic [7:0] b;
		b = 8'h00;
		b[`RSM_SUPPLY_EN_BIT] = en;
		b[`RSM_SUPPLY_MODE_BIT] = act;
		// Detection flag only while detection is enabled
		b[`RSM_SUPPLY_FLAG_BIT] = en & below;
		return b;
	endfunction

	// Write-zero-to-clear: a one leaves the flag as it stands
	function automatic logic clearOnZero(input logic cur, input logic wbit);
		logic r;
		r = cur & wbit;
		return r;
	endfunction

	// ------------------------------------------------------------------
	// System control per phase
	// ------------------------------------------------------------------
	// Oscillator restarts on release; clocks only after the settle wait
	function automatic rsm_sys_ctl_type ctlFor(input rsm_phase_type p);
		rsm_sys_ctl_type c;
		c.sysRst = isResetPhase(p);
		c.oscRun = ~c.sysRst;
		c.clkRun = p == PH_RUN;
		c.cpuRun = p == PH_RUN;
		c.pinsHighZ = c.sysRst;
		c.periphInit = c.sysRst;
		// CPU divider restarts at one eighth each reset
		c.cpuClkDivLog2 = `RSM_CPU_DIV_LOG2;
		return c;
	endfunction

	rsm_state_type s_q;
	rsm_state_type s_d;

	localparam rsm_state_type RESET_STATE = '{
		sync1: 3'h0,
		sync2: 3'h0,
		phase: PH_HOLD,
		cnt: 17'h0,
		wdtFlag: 1'b0,
		lvFlag: 1'b0,
		lvEnable: 1'b0,
		lvAction: 1'b0,
		protArmed: 1'b0,
		ack: 1'b0,
		rdat: 32'h0,
		lviIrq: 1'b0,
		ramSuspect: 1'b1,
		ctl: '{
			sysRst: 1'b1,
			oscRun: 1'b0,
			clkRun: 1'b0,
			cpuRun: 1'b0,
			pinsHighZ: 1'b1,
			periphInit: 1'b1,
			cpuClkDivLog2: `RSM_CPU_DIV_LOG2
		}
	};

	logic [2:0] rawIn;
	assign rawIn = {supplyBelow, porDetect, resetPinN};

	always_comb
	begin
		logic pinRst;
		logic porRst;
		logic below;
		logic lviRst;
		logic wdtRst;
		logic holdRst;
		logic inReset;
		logic busReq;
		logic busWrite;
		logic lane0;
		logic [7:0] wbyte;
		logic keyHit;
		rsm_reg_type sel;
		pinRst = 1'b0;
		porRst = 1'b0;
		below = 1'b0;
		lviRst = 1'b0;
		wdtRst = 1'b0;
		holdRst = 1'b0;
		inReset = 1'b0;
		busReq = 1'b0;
		busWrite = 1'b0;
		lane0 = 1'b0;
		wbyte = 8'h0;
		keyHit = 1'b0;
		sel = RS_NONE;
		s_d = s_q;

		// --------------------------------------------------------------
		// Source conditioning
		// --------------------------------------------------------------
		// Pin and analogue detector levels are asynchronous here
		for (int i = 0; i < 3; i++)
		begin
			s_d.sync1[i] = rawIn[i];
			s_d.sync2[i] = s_q.sync1[i];
		end
		pinRst = ~s_q.sync2[0];
		porRst = s_q.sync2[1];
		// Comparator already set to the chosen level; keeps running in
		// halt, idle and stop since this logic never gates its clock
		below = s_q.sync2[2];
		lviRst = s_q.lvEnable & s_q.lvAction & below;
		wdtRst = wdtOverflow & wdtResetMode;
		holdRst = pinRst | porRst | lviRst;
		inReset = isResetPhase(s_q.phase);

		// --------------------------------------------------------------
		// Bus slave
		// --------------------------------------------------------------
		busReq = wbReq.cyc & wbReq.stb;
		sel = decodeReg(wbReq.adr);
		lane0 = wbReq.sel[0];
		wbyte = wbReq.dat[7:0];
		keyHit = (sel == RS_PROTECT) && (wbyte == PROTECT_KEY);
		// Registered ack: data latched on first edge, write on second
		s_d.ack = busReq & ~s_q.ack;
		busWrite = busReq & s_q.ack & wbReq.we & lane0;
		if (busReq && !s_q.ack)
		begin
			s_d.rdat = 32'h0;
			case (sel)
				RS_CAUSE:
				begin
					// Bit 0 is write-only and reads zero
					s_d.rdat[7:0] = causeImage(s_q.wdtFlag);
				end
				RS_LVCAUSE:
				begin
					s_d.rdat[7:0] = lvCauseImage(s_q.lvFlag);
				end
				RS_SUPPLY:
				begin
					s_d.rdat[7:0] = supplyImage(s_q.lvEnable,
						s_q.lvAction, below);
				end
				default: s_d.rdat = 32'h0;
			endcase
		end
		if (busWrite)
		begin
			// Any completed write other than the unlock disarms
			s_d.protArmed = keyHit;
			case (sel)
				RS_CAUSE:
				begin
					if (s_q.protArmed)
					begin
						// Only zeros act; ones are ignored
						s_d.wdtFlag = clearOnZero(s_q.wdtFlag,
							wbyte[`RSM_CAUSE_WDT_BIT]);
						s_d.lvFlag = clearOnZero(s_q.lvFlag,
							wbyte[`RSM_CAUSE_LVCLR_BIT]);
					end
				end
				RS_SUPPLY:
				begin
					// Reset action locks the monitor settings until a
					// non-monitor reset
					if (s_q.protArmed && !s_q.lvAction)
					begin
						s_d.lvEnable = wbyte[`RSM_SUPPLY_EN_BIT];
						s_d.lvAction = wbyte[`RSM_SUPPLY_MODE_BIT];
					end
				end
				default: s_d.protArmed = s_d.protArmed;
			endcase
		end

		// --------------------------------------------------------------
		// Reset sequencing
		// --------------------------------------------------------------
		case (s_q.phase)
			PH_HOLD:
			begin
				s_d.cnt = 17'h0;
				if (!holdRst)
					s_d.phase = PH_SETTLE;
			end
			PH_WDT:
			begin
				s_d.cnt = s_q.cnt + 17'h1;
				if (holdRst)
					s_d.phase = PH_HOLD;
				else if (s_q.cnt == WDT_LAST)
				begin
					s_d.phase = PH_SETTLE;
					s_d.cnt = 17'h0;
				end
			end
			PH_SETTLE:
			begin
				s_d.cnt = s_q.cnt + 17'h1;
				if (holdRst)
					s_d.phase = PH_HOLD;
				else if (wdtRst)
				begin
					s_d.phase = PH_WDT;
					s_d.cnt = 17'h0;
				end
				else if (s_q.cnt == SETTLE_LAST)
					s_d.phase = PH_RUN;
			end
			PH_RUN:
			begin
				s_d.cnt = 17'h0;
				if (holdRst)
					s_d.phase = PH_HOLD;
				else if (wdtRst)
					s_d.phase = PH_WDT;
			end
			default: s_d.phase = PH_HOLD;
		endcase

		// --------------------------------------------------------------
		// Cause capture; after the bus so a set beats a clear
		// --------------------------------------------------------------
		if (wdtRst && !inReset && !holdRst)
		begin
			s_d.wdtFlag = 1'b1;
			s_d.lvEnable = 1'b0;
			s_d.lvAction = 1'b0;
		end
		if (lviRst)
		begin
			// Watchdog flag left as it was
			s_d.lvFlag = 1'b1;
			s_d.lvEnable = SUPPLY_LV[`RSM_SUPPLY_EN_BIT];
			s_d.lvAction = SUPPLY_LV[`RSM_SUPPLY_MODE_BIT];
		end
		if (pinRst || porRst)
		begin
			s_d.wdtFlag = 1'b0;
			s_d.lvFlag = 1'b0;
			s_d.lvEnable = 1'b0;
			s_d.lvAction = 1'b0;
		end

		// RAM is flagged when reset met power-on or a live CPU write
		if (!inReset && (holdRst || wdtRst))
			s_d.ramSuspect = porRst | ramWriteActive;
		else if (porRst)
			s_d.ramSuspect = 1'b1;

		// --------------------------------------------------------------
		// Registered outputs
		// --------------------------------------------------------------
		s_d.lviIrq = s_d.lvEnable & ~s_d.lvAction & below;
		s_d.ctl = ctlFor(s_d.phase);
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
			s_q <= RESET_STATE;
		else
			s_q <= s_d;
	end

	assign wbRsp.ack = s_q.ack;
	assign wbRsp.dat = s_q.rdat;
	assign sysCtl = s_q.ctl;
	assign supplyMonitorIrq = s_q.lviIrq;
	assign ramDataSuspect = s_q.ramSuspect;

endmodule

// ==== rtl/rsm_cfg.svh ====
`ifndef RSM_CFG_SVH
`define RSM_CFG_SVH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define RSM_ADDR_CAUSE 32'hfffff888
`define RSM_ADDR_LVCAUSE 32'hfffff88c
`define RSM_ADDR_SUPPLY 32'hfffff890
`define RSM_ADDR_PROTECT 32'hfffff8fc

// ----------------------------------------------------------------------
// Protection
// ----------------------------------------------------------------------
`define RSM_PROTECT_KEY 8'ha5

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RSM_CAUSE_WDT_BIT 4
`define RSM_CAUSE_LVCLR_BIT 0
`define RSM_LVCAUSE_FLAG_BIT 0
`define RSM_SUPPLY_EN_BIT 7
`define RSM_SUPPLY_MODE_BIT 1
`define RSM_SUPPLY_FLAG_BIT 0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RSM_CAUSE_RESET 8'h00
`define RSM_LVCAUSE_RESET 8'h00
`define RSM_SUPPLY_RESET 8'h00
`define RSM_SUPPLY_LVRESET 8'h82
`define RSM_CPU_DIV_LOG2 3'h3

// ----------------------------------------------------------------------
// Timing, in ref_clk cycles
// ----------------------------------------------------------------------
`define RSM_SETTLE_OSC_CYCLES 65536
`define RSM_WDT_HOLD_CYCLES 16

`endif

// ==== rtl/rsm_pkg.sv ====
`include "rsm_cfg.svh"

package rsm_pkg;

	// ------------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [31:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} rsm_wb_req_type;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} rsm_wb_rsp_type;

	typedef struct packed {
		logic sysRst;
		logic oscRun;
		logic clkRun;
		logic cpuRun;
		logic pinsHighZ;
		logic periphInit;
		logic [2:0] cpuClkDivLog2;
	} rsm_sys_ctl_type;

	// ------------------------------------------------------------------
	// Enumerations
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		PH_HOLD,
		PH_WDT,
		PH_SETTLE,
		PH_RUN
	} rsm_phase_type;

	typedef enum logic [2:0] {
		RS_NONE,
		RS_CAUSE,
		RS_LVCAUSE,
		RS_SUPPLY,
		RS_PROTECT
	} rsm_reg_type;

	// ------------------------------------------------------------------
	// Whole block state
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [2:0] sync1;
		logic [2:0] sync2;
		rsm_phase_type phase;
		logic [16:0] cnt;
		logic wdtFlag;
		logic lvFlag;
		logic lvEnable;
		logic lvAction;
		logic protArmed;
		logic ack;
		logic [31:0] rdat;
		logic lviIrq;
		logic ramSuspect;
		rsm_sys_ctl_type ctl;
	} rsm_state_type;

endpackage

// ==== dv/rsm_src_model.sv ====
module rsm_src_model
(
	input wire logic ref_clk,
	input wire logic pinLow,
	input wire logic porOn,
	input wire logic lowSupply,
	output logic resetPinN,
	output logic porDetect,
	output logic supplyBelow
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		resetPinN = 1'b0;
		porDetect = 1'b0;
		supplyBelow = 1'b0;
	end
	// Board pin and comparators; one cycle late, like a slow edge
	always @(posedge ref_clk)
	begin
		resetPinN <= !pinLow;
		porDetect <= porOn;
		supplyBelow <= lowSupply;
	end
endmodule

// ==== dv/rsm_reset_ctrl_monitor.sv ====
module rsm_reset_ctrl_chk
	import rsm_pkg::*;
#(
	parameter int SETTLE_CYCLES = 16
)
(
	input wire logic ref_clk,
	input wire logic srst,
	input rsm_wb_req_type wbReq,
	input rsm_wb_rsp_type wbRsp,
	input wire logic resetPinN,
	input wire logic porDetect,
	input wire logic supplyBelow,
	input wire logic wdtOverflow,
	input wire logic wdtResetMode,
	input wire logic ramWriteActive,
	input rsm_sys_ctl_type sysCtl,
	input wire logic supplyMonitorIrq,
	input wire logic ramDataSuspect
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (srst);
	// Cycles since the last release, frozen once the CPU runs
	int settleCnt;
	always_ff @(posedge ref_clk)
	begin
		if (srst || sysCtl.sysRst)
			settleCnt <= 0;
		else if (!sysCtl.cpuRun)
			settleCnt <= settleCnt + 1;
	end
	sequence req_s;
		$rose(wbReq.stb) && wbReq.cyc;
	endsequence
	sequence rel_s;
		$fell(sysCtl.sysRst);
	endsequence
	chk_ack_pulse: assert property (req_s |=> wbRsp.ack ##1 !wbRsp.ack)
		else $error("ack not one cycle");
	chk_settle_wait: assert property (
		rel_s |-> (!sysCtl.cpuRun)[*8] ##[1:12] sysCtl.cpuRun)
		else $error("cpu start not after settle");
	chk_settle_exact: assert property (
		$rose(sysCtl.cpuRun) |-> settleCnt == SETTLE_CYCLES)
		else $error("settle wait length wrong");
	chk_reset_state: assert property (
		sysCtl.sysRst |-> !sysCtl.oscRun && !sysCtl.cpuRun &&
		!sysCtl.clkRun && sysCtl.pinsHighZ && sysCtl.periphInit)
		else $error("bad state in reset");
	chk_run_state: assert property (
		sysCtl.cpuRun |-> sysCtl.oscRun && sysCtl.clkRun &&
		!sysCtl.pinsHighZ && !sysCtl.periphInit)
		else $error("bad state in run");
	chk_cpu_div: assert property (sysCtl.cpuClkDivLog2 == 3'h3)
		else $error("cpu clock not div 8");
	chk_pin_hold: assert property (!resetPinN[*3] |=> sysCtl.sysRst)
		else $error("pin low without reset");
	chk_wdt_hold: assert property (
		wdtOverflow && wdtResetMode && sysCtl.cpuRun |=> sysCtl.sysRst[*8])
		else $error("watchdog reset too short");
	chk_irq_quiet: assert property (
		!supplyBelow[*4] |-> !supplyMonitorIrq)
		else $error("irq with supply good");
endmodule

bind rsm_reset_ctrl rsm_reset_ctrl_chk #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (
	.ref_clk(ref_clk), .srst(srst), .wbReq(wbReq), .wbRsp(wbRsp),
	.resetPinN(resetPinN), .porDetect(porDetect),
	.supplyBelow(supplyBelow), .wdtOverflow(wdtOverflow),
	.wdtResetMode(wdtResetMode), .ramWriteActive(ramWriteActive),
	.sysCtl(sysCtl), .supplyMonitorIrq(supplyMonitorIrq),
	.ramDataSuspect(ramDataSuspect));

// ==== dv/rsm_testbench.sv ====
`include "rsm_cfg.svh"

module testbench
	import rsm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] AC = `RSM_ADDR_CAUSE;
	localparam logic [31:0] AL = `RSM_ADDR_LVCAUSE;
	localparam logic [31:0] AS = `RSM_ADDR_SUPPLY;
	logic ref_clk, srst, wdtOverflow, wdtResetMode, ramWriteActive;
	logic pinLow, porOn, lowSupply, resetPinN, porDetect, supplyBelow;
	logic supplyMonitorIrq, ramDataSuspect;
	rsm_wb_req_type wbReq;
	rsm_wb_rsp_type wbRsp;
	rsm_sys_ctl_type sysCtl;
	int miscompares, checks_done, cycles;
	logic [31:0] rd;
	rsm_reset_ctrl #(.SETTLE_CYCLES(16)) uut (.ref_clk(ref_clk),
		.srst(srst), .wbReq(wbReq), .wbRsp(wbRsp), .resetPinN(resetPinN),
		.porDetect(porDetect), .supplyBelow(supplyBelow),
		.wdtOverflow(wdtOverflow), .wdtResetMode(wdtResetMode),
		.ramWriteActive(ramWriteActive), .sysCtl(sysCtl),
		.supplyMonitorIrq(supplyMonitorIrq),
		.ramDataSuspect(ramDataSuspect));
	rsm_src_model src (.ref_clk(ref_clk), .pinLow(pinLow), .porOn(porOn),
		.lowSupply(lowSupply), .resetPinN(resetPinN),
		.porDetect(porDetect), .supplyBelow(supplyBelow));
	initial
	begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			tally_and_finish();
		end
	end
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			miscompares++;
			$display("wrong value %s: expected %h seen %h", n, e, g);
		end
	endtask
	// ------------------------------------------------------------------
	// Bus cycles, always entered just after a rising edge
	// ------------------------------------------------------------------
	task automatic wb(logic w, logic [31:0] a, logic [7:0] d);
		wbReq <= '{1'b1, 1'b1, w, a, 4'h1, {24'h0, d}};
		do @(posedge ref_clk); while (wbRsp.ack !== 1'b1);
		rd = wbRsp.dat;
		wbReq <= '0;
		@(posedge ref_clk);
	endtask
	task automatic pw(logic [31:0] a, logic [7:0] d);
		wb(1'b1, `RSM_ADDR_PROTECT, `RSM_PROTECT_KEY);
		wb(1'b1, a, d);
	endtask
	task automatic rdc(string n, logic [31:0] a, logic [7:0] e);
		wb(1'b0, a, 8'h00);
		chk(n, {24'h0, e}, rd);
	endtask
	task automatic wait_run;
		while (sysCtl.sysRst !== 1'b1)
			@(posedge ref_clk);
		while (sysCtl.cpuRun !== 1'b1)
			@(posedge ref_clk);
	endtask
	initial
	begin
		srst = 1'b1;
		wbReq = '0;
		{wdtOverflow, wdtResetMode, ramWriteActive, porOn, lowSupply} = '0;
		pinLow = 1'b1;
		{cycles, miscompares, checks_done} = '0;
		rd = $urandom(6515);
		repeat (4) @(posedge ref_clk);
		srst <= 1'b0;
		pinLow <= 1'b0;
		wait_run();
		rdc("cause", AC, 8'h00);
		rdc("lvcause", AL, 8'h00);
		rdc("supply", AS, 8'h00);
		chk("ram", 1, ramDataSuspect);
		$display("power-on test done");
		wdtResetMode <= 1'b1;
		wdtOverflow <= 1'b1;
		@(posedge ref_clk);
		wdtOverflow <= 1'b0;
		wait_run();
		rdc("cause", AC, 8'h10);
		rdc("lvcause", AL, 8'h00);
		chk("ram", 0, ramDataSuspect);
		wb(1'b1, AC, 8'h00);
		rdc("cause", AC, 8'h10);
		pw(AC, 8'hff);
		rdc("cause", AC, 8'h10);
		$display("watchdog test done");
		lowSupply <= 1'b1;
		wb(1'b1, AS, 8'h80);
		rdc("supply", AS, 8'h00);
		pw(AS, 8'h80);
		rdc("supply", AS, 8'h81);
		chk("irq", 1, supplyMonitorIrq);
		lowSupply <= 1'b0;
		repeat (5) @(posedge ref_clk);
		rdc("supply", AS, 8'h80);
		chk("irq", 0, supplyMonitorIrq);
		$display("interrupt test done");
		lowSupply <= 1'b1;
		ramWriteActive <= 1'b1;
		pw(AS, 8'h82);
		repeat ($urandom_range(20, 4)) @(posedge ref_clk);
		lowSupply <= 1'b0;
		ramWriteActive <= 1'b0;
		wait_run();
		rdc("supply", AS, 8'h82);
		rdc("lvcause", AL, 8'h01);
		rdc("cause", AC, 8'h10);
		chk("ram", 1, ramDataSuspect);
		pw(AS, 8'h00);
		rdc("supply", AS, 8'h82);
		wb(1'b1, AL, 8'($urandom));
		rdc("lvcause", AL, 8'h01);
		pw(AC, 8'h10);
		rdc("lvcause", AL, 8'h00);
		rdc("cause", AC, 8'h10);
		rdc("unmapped", 32'hfffff800, 8'h00);
		$display("monitor reset test done");
		pinLow <= 1'b1;
		repeat ($urandom_range(30, 5)) @(posedge ref_clk);
		chk("sysRst", 1, sysCtl.sysRst);
		pinLow <= 1'b0;
		wait_run();
		rdc("cause", AC, 8'h00);
		rdc("supply", AS, 8'h00);
		rdc("lvcause", AL, 8'h00);
		chk("ram", 0, ramDataSuspect);
		pw(AS, 8'h80);
		rdc("supply", AS, 8'h80);
		$display("pin reset test done");
		wdtOverflow <= 1'b1;
		@(posedge ref_clk);
		wdtOverflow <= 1'b0;
		wait_run();
		rdc("supply", AS, 8'h00);
		rdc("cause", AC, 8'h10);
		porOn <= 1'b1;
		repeat ($urandom_range(12, 5)) @(posedge ref_clk);
		chk("sysRst", 1, sysCtl.sysRst);
		porOn <= 1'b0;
		wait_run();
		rdc("cause", AC, 8'h00);
		rdc("lvcause", AL, 8'h00);
		chk("ram", 1, ramDataSuspect);
		$display("power-on clear test done");
		tally_and_finish();
	end
endmodule
